// File: pkg/irq_pkg.sv
// Shared types, register layout and reset values of the interrupt controller
package irq_pkg;

    localparam int NSRC = 6;

    // Register select on the special function register port
    typedef enum logic [1:0] {
        SEL_EDGE  = 2'h0,
        SEL_CTL_A = 2'h1,
        SEL_CTL_B = 2'h2,
        SEL_GRP   = 2'h3
    } reg_sel_t;

    // External pin edge selection codes
    typedef enum logic [1:0] {
        EDGE_OFF  = 2'b00,
        EDGE_RISE = 2'b01,
        EDGE_FALL = 2'b10,
        EDGE_BOTH = 2'b11
    } edge_sel_t;

    // Vector index handed to the core; a lower code wins on a tie
    typedef enum logic [2:0] {
        VEC_PIN      = 3'h0,
        VEC_TOUCH    = 3'h1,
        VEC_GROUPED  = 3'h2,
        VEC_TIMEBASE = 3'h3,
        VEC_EEPROM   = 3'h4,
        VEC_SERIAL   = 3'h5
    } vec_t;

    // Register write from the core
    typedef struct packed {
        logic     wr;
        reg_sel_t sel;
        logic [7:0] wdata;
    } sfr_req_t;

    // One-cycle event pulses from the on-chip sources
    typedef struct packed {
        logic touch;
        logic timebase;
        logic eeprom;
        logic serial;
        logic cmp_a;
        logic cmp_p;
    } src_evt_t;

    // Bit positions in primary_irq_control_a
    localparam int A_GIE       = 0;
    localparam int A_PIN_EN    = 1;
    localparam int A_TOUCH_EN  = 2;
    localparam int A_GRP_EN    = 3;
    localparam int A_PIN_FLG   = 4;
    localparam int A_TOUCH_FLG = 5;
    localparam int A_GRP_FLG   = 6;
    // Bit positions in primary_irq_control_b
    localparam int B_SER_EN    = 0;
    localparam int B_TB_EN     = 1;
    localparam int B_EE_EN     = 2;
    localparam int B_SER_FLG   = 4;
    localparam int B_TB_FLG    = 5;
    localparam int B_EE_FLG    = 6;
    // Bit positions in grouped_irq_control
    localparam int G_P_EN      = 0;
    localparam int G_A_EN      = 1;
    localparam int G_P_FLG     = 4;
    localparam int G_A_FLG     = 5;

    // Implemented bits of each register
    localparam logic [7:0] EDGE_MASK  = 8'h03;
    localparam logic [7:0] CTL_A_MASK = 8'h7F;
    localparam logic [7:0] CTL_B_MASK = 8'h77;
    localparam logic [7:0] GRP_MASK   = 8'h33;
    // Flag bits, used to spot a flag becoming set
    localparam logic [7:0] CTL_A_FLGS = 8'h70;
    localparam logic [7:0] CTL_B_FLGS = 8'h70;
    localparam logic [7:0] GRP_FLGS   = 8'h30;

    localparam logic [7:0] CTL_RST    = 8'h00;

endpackage

// File: core/pin_edge_detect.sv
// External request pin synchroniser and edge selector
module pin_edge_detect (
    input  wire logic             ref_clk,
    input  wire logic             srst,
    input  wire logic             pin_in,
    input  irq_pkg::edge_sel_t    mode,
    output logic                  edge_hit
);
    import irq_pkg::*;

    logic sync1_r, sync2_r, prev_r, hit_r;
    logic prev_nxt, hit_nxt;

    // Edge choice; the first sync stage is seen only by the second
    always_comb begin
        prev_nxt = sync2_r;
        unique case (mode)
            EDGE_OFF:  hit_nxt = 1'b0;
            EDGE_RISE: hit_nxt = sync2_r & ~prev_r;
            EDGE_FALL: hit_nxt = ~sync2_r & prev_r;
            EDGE_BOTH: hit_nxt = sync2_r ^ prev_r;
        endcase
    end

    // Two flops before any logic, then the edge history
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            prev_r  <= 1'b0;
            hit_r   <= 1'b0;
        end else begin
            sync1_r <= pin_in;
            sync2_r <= sync1_r;
            prev_r  <= prev_nxt;
            hit_r   <= hit_nxt;
        end
    end

    assign edge_hit = hit_r;

endmodule

// File: core/irq_priority.sv
// Fixed priority pick among pending enabled sources
module irq_priority (
    input  wire logic [irq_pkg::NSRC-1:0] pend,
    output logic                          any,
    output irq_pkg::vec_t                 vec
);
    import irq_pkg::*;

    // Scan from the top so the lowest index is left standing
    always_comb begin
        vec = VEC_PIN;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (pend[i]) begin
                vec = vec_t'(i[2:0]);
            end
        end
        any = |pend;
    end

endmodule

// File: core/irq_ctrl.sv
// Interrupt request flags, enables, global enable and vector request
// How it works
// - Edge field picks off, rising, falling or both edges on the pin.
// - Unimplemented register bits always read back as zero.
// - Each source has one enable bit and one request flag.
// - Pin flag is bit 4, pin enable bit 1 of control A.
// - Touch flag bit 5, touch enable bit 2 of control A, reset zero.
// - Grouped flag bit 6, grouped enable bit 3 of control A.
// - Grouped register holds comparator A flag bit 5, enable bit 1.
// - Grouped register holds comparator P flag bit 4, enable bit 0.
// - Control B holds EEPROM flag bit 6 and enable bit 2.
// - Control B holds time base flag bit 5 and enable bit 1.
// - Two primary registers, one grouped register, one edge register.
// - Request needs own enable and global enable; flags still set.
// - Service clears global enable; later events still latch flags.
// - Service clears the serviced source's flag.
// - Any flag becoming set raises wake, enabled or not.
module irq_ctrl (
    input  wire logic              ref_clk,
    input  wire logic              srst,
    input  irq_pkg::sfr_req_t      sfr,
    output logic [7:0]             sfr_rdata,
    input  wire logic              ext_pin,
    input  irq_pkg::src_evt_t      src_evt,
    input  wire logic              stack_full,
    input  wire logic              irq_ack,
    output logic                   irq_req,
    output irq_pkg::vec_t          irq_vec,
    output logic                   wake
);
    import irq_pkg::*;

    // Implemented-bit mask of a register, used on write and read
    function automatic logic [7:0] sel_mask(input reg_sel_t s);
        unique case (s)
            SEL_EDGE:  sel_mask = EDGE_MASK;
            SEL_CTL_A: sel_mask = CTL_A_MASK;
            SEL_CTL_B: sel_mask = CTL_B_MASK;
            SEL_GRP:   sel_mask = GRP_MASK;
        endcase
    endfunction

    logic [7:0]      edge_r, edge_nxt;
    logic [7:0]      ctl_a_r, ctl_a_nxt;
    logic [7:0]      ctl_b_r, ctl_b_nxt;
    logic [7:0]      grp_r, grp_nxt;
    logic            req_r, req_nxt;
    vec_t            vec_r, vec_nxt;
    logic            wake_r, wake_nxt;
    logic [7:0]      rd_r, rd_nxt;
    logic            pin_hit;
    logic            serviced;
    logic            grp_set;
    logic [NSRC-1:0] pend;
    logic            pend_any;
    vec_t            pick;

    // Pin edge detection under control of the edge field
    pin_edge_detect u_edge (
        .ref_clk  (ref_clk),
        .srst     (srst),
        .pin_in   (ext_pin),
        .mode     (edge_sel_t'(edge_r[1:0])),
        .edge_hit (pin_hit)
    );

    // Service is only taken while a request stands
    assign serviced = irq_ack & req_r;

    // Either comparator event with its own enable raises the grouped flag
    assign grp_set = (src_evt.cmp_a & grp_r[G_A_EN])
                   | (src_evt.cmp_p & grp_r[G_P_EN]);

    // Pending and enabled sources, from the state about to be stored
    always_comb begin
        pend[VEC_PIN]      = ctl_a_nxt[A_PIN_FLG] & ctl_a_nxt[A_PIN_EN];
        pend[VEC_TOUCH]    = ctl_a_nxt[A_TOUCH_FLG] & ctl_a_nxt[A_TOUCH_EN];
        pend[VEC_GROUPED]  = ctl_a_nxt[A_GRP_FLG] & ctl_a_nxt[A_GRP_EN];
        pend[VEC_TIMEBASE] = ctl_b_nxt[B_TB_FLG] & ctl_b_nxt[B_TB_EN];
        pend[VEC_EEPROM]   = ctl_b_nxt[B_EE_FLG] & ctl_b_nxt[B_EE_EN];
        pend[VEC_SERIAL]   = ctl_b_nxt[B_SER_FLG] & ctl_b_nxt[B_SER_EN];
    end

    irq_priority u_prio (
        .pend (pend),
        .any  (pend_any),
        .vec  (pick)
    );

    // Register next values: software write, then service clear, then
    // hardware sets last so an event in the clearing cycle is kept
    always_comb begin
        edge_nxt  = edge_r;
        ctl_a_nxt = ctl_a_r;
        ctl_b_nxt = ctl_b_r;
        grp_nxt   = grp_r;
        if (sfr.wr) begin
            unique case (sfr.sel)
                SEL_EDGE:  edge_nxt  = sfr.wdata & sel_mask(SEL_EDGE);
                SEL_CTL_A: ctl_a_nxt = sfr.wdata & sel_mask(SEL_CTL_A);
                SEL_CTL_B: ctl_b_nxt = sfr.wdata & sel_mask(SEL_CTL_B);
                SEL_GRP:   grp_nxt   = sfr.wdata & sel_mask(SEL_GRP);
            endcase
        end
        if (serviced) begin
            ctl_a_nxt[A_GIE] = 1'b0;
            unique case (vec_r)
                VEC_PIN:      ctl_a_nxt[A_PIN_FLG]   = 1'b0;
                VEC_TOUCH:    ctl_a_nxt[A_TOUCH_FLG] = 1'b0;
                VEC_GROUPED:  ctl_a_nxt[A_GRP_FLG]   = 1'b0;
                VEC_TIMEBASE: ctl_b_nxt[B_TB_FLG]    = 1'b0;
                VEC_EEPROM:   ctl_b_nxt[B_EE_FLG]    = 1'b0;
                VEC_SERIAL:   ctl_b_nxt[B_SER_FLG]   = 1'b0;
                default:      ctl_a_nxt[A_GIE]       = 1'b0;
            endcase
        end
        // Flags latch regardless of their own enables and global enable; the grouped flag needs a comparator enable
        if (pin_hit) begin
            ctl_a_nxt[A_PIN_FLG] = 1'b1;
        end
        if (src_evt.touch) begin
            ctl_a_nxt[A_TOUCH_FLG] = 1'b1;
        end
        if (grp_set) begin
            ctl_a_nxt[A_GRP_FLG] = 1'b1;
        end
        if (src_evt.timebase) begin
            ctl_b_nxt[B_TB_FLG] = 1'b1;
        end
        if (src_evt.eeprom) begin
            ctl_b_nxt[B_EE_FLG] = 1'b1;
        end
        if (src_evt.serial) begin
            ctl_b_nxt[B_SER_FLG] = 1'b1;
        end
        if (src_evt.cmp_a) begin
            grp_nxt[G_A_FLG] = 1'b1;
        end
        if (src_evt.cmp_p) begin
            grp_nxt[G_P_FLG] = 1'b1;
        end
    end

    // Request, vector and wake computed from next state, read data from current state,
    // so a serviced request drops in the same edge that clears its flag
    always_comb begin
        req_nxt  = ctl_a_nxt[A_GIE] & pend_any & ~stack_full;
        vec_nxt  = pick;
        wake_nxt = |((ctl_a_nxt & ~ctl_a_r) & CTL_A_FLGS)
                 | |((ctl_b_nxt & ~ctl_b_r) & CTL_B_FLGS)
                 | |((grp_nxt & ~grp_r) & GRP_FLGS);
        unique case (sfr.sel)
            SEL_EDGE:  rd_nxt = edge_r & sel_mask(SEL_EDGE);
            SEL_CTL_A: rd_nxt = ctl_a_r & sel_mask(SEL_CTL_A);
            SEL_CTL_B: rd_nxt = ctl_b_r & sel_mask(SEL_CTL_B);
            SEL_GRP:   rd_nxt = grp_r & sel_mask(SEL_GRP);
        endcase
    end

    // State registers; everything clears on reset, global enable included
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            edge_r  <= CTL_RST;
            ctl_a_r <= CTL_RST;
            ctl_b_r <= CTL_RST;
            grp_r   <= CTL_RST;
            req_r   <= 1'b0;
            vec_r   <= VEC_PIN;
            wake_r  <= 1'b0;
            rd_r    <= CTL_RST;
        end else begin
            edge_r  <= edge_nxt;
            ctl_a_r <= ctl_a_nxt;
            ctl_b_r <= ctl_b_nxt;
            grp_r   <= grp_nxt;
            req_r   <= req_nxt;
            vec_r   <= vec_nxt;
            wake_r  <= wake_nxt;
            rd_r    <= rd_nxt;
        end
    end

    assign sfr_rdata = rd_r;
    assign irq_req   = req_r;
    assign irq_vec   = vec_r;
    assign wake      = wake_r;

    // Checks on the controller's own behaviour
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    sequence s_service;
        req_r && irq_ack;
    endsequence

    sequence s_quiet_sw;
        !sfr.wr;
    endsequence

    a_edge_off_quiet: assert property (
        (edge_r[1:0] == EDGE_OFF) [*2] |-> !pin_hit)
        else $error("pin hit while edge detection is off");

    a_reserved_read_zero: assert property (
        (rd_r & ~sel_mask($past(sfr.sel))) == 8'h00)
        else $error("unimplemented bit read as one");

    a_req_needs_gie: assert property (
        req_r |-> ctl_a_r[A_GIE] && !$past(stack_full))
        else $error("request without global enable");

    a_req_own_enable: assert property (
        req_r && vec_r == VEC_TIMEBASE |-> ctl_b_r[B_TB_FLG] && ctl_b_r[B_TB_EN])
        else $error("time base request without flag and enable");

    a_service_gie_clear: assert property (
        s_service ##0 s_quiet_sw |=> !ctl_a_r[A_GIE] ##1 !req_r)
        else $error("global enable not cleared on service");

    a_service_flag_clear: assert property (
        s_service ##0 s_quiet_sw ##0 (vec_r == VEC_TOUCH && !src_evt.touch)
        |=> !ctl_a_r[A_TOUCH_FLG])
        else $error("serviced touch flag not cleared");

    a_event_latched: assert property (
        src_evt.touch |=> ctl_a_r[A_TOUCH_FLG])
        else $error("touch event lost");

    a_pin_latched: assert property (
        pin_hit |=> ctl_a_r[A_PIN_FLG])
        else $error("pin edge lost");

    a_grp_from_cmp: assert property (
        src_evt.cmp_a && grp_r[G_A_EN] |=> ctl_a_r[A_GRP_FLG] && grp_r[G_A_FLG])
        else $error("comparator A did not raise grouped flag");

    a_pin_first: assert property (
        req_r && ctl_a_r[A_PIN_FLG] && ctl_a_r[A_PIN_EN] |-> vec_r == VEC_PIN)
        else $error("pin request lost priority");

    a_wake_on_set: assert property (
        src_evt.timebase && !ctl_b_r[B_TB_FLG] |=> wake_r)
        else $error("no wake on time base flag");

    // Plain writes land masked when no hardware event or service meets them
    sequence s_write_b;
        sfr.wr && sfr.sel == SEL_CTL_B;
    endsequence

    sequence s_write_grp;
        sfr.wr && sfr.sel == SEL_GRP;
    endsequence

    a_reset_clears: assert property (
        $fell(srst) |-> edge_r == CTL_RST && ctl_a_r == CTL_RST && ctl_b_r == CTL_RST
                        && grp_r == CTL_RST && !req_r && !wake_r)
        else $error("state not cleared by reset");

    a_edge_write: assert property (
        sfr.wr && sfr.sel == SEL_EDGE |=> edge_r == ($past(sfr.wdata) & EDGE_MASK))
        else $error("edge register write lost");

    a_ctl_b_write: assert property (
        s_write_b ##0 (!serviced && !src_evt.timebase && !src_evt.eeprom && !src_evt.serial)
        |=> ctl_b_r == ($past(sfr.wdata) & CTL_B_MASK))
        else $error("control B write lost");

    a_grp_write: assert property (
        s_write_grp ##0 (!src_evt.cmp_a && !src_evt.cmp_p)
        |=> grp_r == ($past(sfr.wdata) & GRP_MASK))
        else $error("grouped register write lost");

    a_rd_ctl_a: assert property (
        sfr.sel == SEL_CTL_A |=> rd_r == $past(ctl_a_r))
        else $error("control A read back wrong");

    // Every source flag latches on its event, whatever software does that cycle
    a_cmp_a_latched: assert property (
        src_evt.cmp_a |=> grp_r[G_A_FLG])
        else $error("comparator A event lost");

    a_cmp_p_latched: assert property (
        src_evt.cmp_p |=> grp_r[G_P_FLG])
        else $error("comparator P event lost");

    a_tb_latched: assert property (
        src_evt.timebase |=> ctl_b_r[B_TB_FLG])
        else $error("time base event lost");

    a_ee_latched: assert property (
        src_evt.eeprom |=> ctl_b_r[B_EE_FLG])
        else $error("eeprom event lost");

    a_ser_latched: assert property (
        src_evt.serial |=> ctl_b_r[B_SER_FLG])
        else $error("serial module event lost");

    // Service must shut the request at once, even if software writes alongside
    a_service_drops_req: assert property (
        s_service |=> !req_r && !ctl_a_r[A_GIE])
        else $error("request kept after service");

    a_sw_set_wakes: assert property (
        s_write_b ##0 (!serviced && (sfr.wdata & CTL_B_FLGS & ~ctl_b_r) != 8'h00)
        |=> wake_r)
        else $error("no wake on software flag set");

endmodule

// File: test/cpu_core_model.sv
// Behavioural core that services vector requests after a chosen delay
module cpu_core_model (
    input  wire logic       ref_clk,
    input  wire logic       irq_req,
    input  wire logic       ack_en,
    input  wire logic [2:0] ack_dly,
    output logic            irq_ack
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [2:0] cnt = 3'h0;

    initial begin
        irq_ack = 1'b0;
    end

    // Acknowledge lasts one cycle and is raised only while a request stands,
    // so the controller never sees a stray service pulse
    always @(negedge ref_clk) begin
        if (irq_ack || !irq_req || !ack_en) begin
            irq_ack <= 1'b0;
            cnt     <= 3'h0;
        end else if (cnt == ack_dly) begin
            irq_ack <= 1'b1;
        end else begin
            cnt <= cnt + 3'h1;
        end
    end
endmodule

// File: test/irq_ctrl_tb.sv
// Self-checking bench for the interrupt controller and its core model
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
    $display("ERROR t=%0t got=%0h exp=%0h", $time, g, e); end end

module irq_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import irq_pkg::*;

    logic       ref_clk    = 1'b0;
    logic       srst       = 1'b1;
    logic       ext_pin    = 1'b0;
    logic       stack_full = 1'b0;
    logic       ack_en     = 1'b0;
    logic       rd_mark    = 1'b0;
    logic       rd_seen    = 1'b0;
    logic [2:0] ack_dly    = 3'h0;
    sfr_req_t   sfr        = '0;
    src_evt_t   src_evt    = '0;
    logic [7:0] sfr_rdata;
    logic       irq_req;
    logic       irq_ack;
    logic       wake;
    vec_t       irq_vec;
    logic [7:0] exp_rd;
    vec_t       exp_vec;
    logic [7:0] rd_q[$];
    vec_t       vec_q[$];
    int         fail_count = 0;
    int         n_checks   = 0;
    int         n_svc      = 0;
    int         wake_cnt   = 0;
    int         exp_wake   = 0;
    localparam logic [7:0] MASKS[4] = '{EDGE_MASK, CTL_A_MASK, CTL_B_MASK, GRP_MASK};

    always #2.5 ref_clk = ~ref_clk;

    irq_ctrl irq_ctrl_i (.ref_clk(ref_clk), .srst(srst), .sfr(sfr), .sfr_rdata(sfr_rdata),
        .ext_pin(ext_pin), .src_evt(src_evt), .stack_full(stack_full), .irq_ack(irq_ack),
        .irq_req(irq_req), .irq_vec(irq_vec), .wake(wake));
    cpu_core_model cpu_core_model_i (.ref_clk(ref_clk), .irq_req(irq_req), .ack_en(ack_en),
        .ack_dly(ack_dly), .irq_ack(irq_ack));

    // Service and wake watcher; an ack with nothing expected is a mismatch
    always @(posedge ref_clk) begin
        rd_seen <= rd_mark;
        if (wake === 1'b1) wake_cnt++;
        if (irq_ack === 1'b1 && irq_req === 1'b1) begin
            n_svc++;
            exp_vec = (vec_q.size() > 0) ? vec_q.pop_front() : vec_t'(3'h7);
            `CHK(irq_vec, exp_vec)
        end
    end

    // Read data lands one cycle after the select
    always @(negedge ref_clk) begin
        if (rd_seen) begin
            exp_rd = rd_q.pop_front();
            `CHK(sfr_rdata, exp_rd)
        end
    end

    task automatic wr(input reg_sel_t s, input logic [7:0] d);
        @(negedge ref_clk);
        sfr = '{wr: 1'b1, sel: s, wdata: d};
        @(negedge ref_clk);
        sfr.wr = 1'b0;
    endtask

    task automatic rd(input reg_sel_t s, input logic [7:0] e);
        @(negedge ref_clk);
        sfr.sel = s;
        rd_q.push_back(e);
        rd_mark = 1'b1;
        @(negedge ref_clk);
        rd_mark = 1'b0;
    endtask

    task automatic fire(input src_evt_t e);
        @(negedge ref_clk);
        src_evt = e;
        @(negedge ref_clk);
        src_evt = '0;
    endtask

    // Bounded wait for the service count; running out ends the run
    task automatic wait_svc(input int n);
        for (int i = 0; i < 64 && n_svc < n; i++) @(negedge ref_clk);
        if (n_svc < n) begin
            fail_count++;
            wrap_up();
        end
    endtask

    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        src_evt_t   e;
        logic [1:0] g;
        logic [7:0] a_rem;
        vec_t       vq[$];
        logic       hit;
        int         base;
        void'($urandom(32'hc54b));
        repeat (16) @(negedge ref_clk);
        srst = 1'b0;
        // Reset values and unimplemented bits; the core ignores requests here
        for (int s = 0; s < 4; s++) begin
            rd(reg_sel_t'(s), 8'h00);
            wr(reg_sel_t'(s), 8'hff);
            rd(reg_sel_t'(s), MASKS[s]);
            wr(reg_sel_t'(s), 8'h00);
        end
        exp_wake += 3;
        $display("Test register map done");
        // Every edge code against a rise then a fall on the pin
        ack_en = 1'b1;
        for (int m = 0; m < 4; m++) begin
            wr(SEL_EDGE, 8'(m));
            for (int d = 0; d < 2; d++) begin
                wr(SEL_CTL_A, 8'h03);
                hit = m[d];
                base = n_svc;
                @(negedge ref_clk);
                ext_pin = ~ext_pin;
                if (hit) begin
                    vec_q.push_back(VEC_PIN);
                    exp_wake++;
                end
                wait_svc(base + int'(hit));
                repeat (6) @(negedge ref_clk);
                rd(SEL_CTL_A, hit ? 8'h02 : 8'h03);
            end
        end
        $display("Test pin edges done");
        // Random simultaneous events served one by one in priority order
        wr(SEL_EDGE, 8'h00);
        for (int k = 0; k < 8; k++) begin
            e = src_evt_t'(6'($urandom));
            g = 2'($urandom);
            ack_dly = 3'($urandom);
            wr(SEL_CTL_A, 8'h0e);
            wr(SEL_CTL_B, 8'h07);
            wr(SEL_GRP, {6'h00, g});
            fire(e);
            repeat (3) @(negedge ref_clk);
            `CHK(irq_req, 1'b0)
            rd(SEL_CTL_B, {1'b0, e.eeprom, e.timebase, e.serial, 4'h7});
            if (e.touch) vq.push_back(VEC_TOUCH);
            if ((e.cmp_a && g[1]) || (e.cmp_p && g[0])) vq.push_back(VEC_GROUPED);
            if (e.timebase) vq.push_back(VEC_TIMEBASE);
            if (e.eeprom) vq.push_back(VEC_EEPROM);
            if (e.serial) vq.push_back(VEC_SERIAL);
            exp_wake += int'(e != '0);
            while (vq.size() > 0) begin
                // Rewrite the global enable without wiping flags still pending
                a_rem = 8'h00;
                foreach (vq[i]) begin
                    if (vq[i] == VEC_TOUCH) a_rem |= 8'h20;
                    if (vq[i] == VEC_GROUPED) a_rem |= 8'h40;
                end
                base = n_svc;
                vec_q.push_back(vq.pop_front());
                stack_full = 1'b1;
                wr(SEL_CTL_A, 8'h0f | a_rem);
                repeat (4) @(negedge ref_clk);
                `CHK(irq_req, 1'b0)
                stack_full = 1'b0;
                wait_svc(base + 1);
            end
            rd(SEL_CTL_A, 8'h0e);
            rd(SEL_CTL_B, 8'h07);
            rd(SEL_GRP, {2'b00, e.cmp_a, e.cmp_p, 2'b00, g});
            wr(SEL_GRP, 8'h00);
        end
        $display("Test random service done");
        `CHK(wake_cnt, exp_wake)
        wrap_up();
    end
endmodule
